// ### src/rst_seq_pkg.sv
package rst_seq_pkg;
  // Configuration word field positions
  localparam int CfgWakeResetBit = 12;
  localparam int CfgDataProtBit = 7;
  localparam int CfgProgProtBit = 6;
  localparam int CfgExtPinBit = 5;
  localparam int CfgPwrtDisBit = 4;
  localparam int CfgWdtBit = 3;
  localparam int CfgOscLsb = 0;
  localparam int CfgOscWidth = 3;

  // Oscillator select codes
  localparam logic [2:0] OscExtRcClkout = 3'h7;
  localparam logic [2:0] OscExtRcIo = 3'h6;
  localparam logic [2:0] OscIntClkout = 3'h5;
  localparam logic [2:0] OscIntIo = 3'h4;

  // Timing
  localparam int ClockHz = 25000000;
  localparam int PwrtMs = 64;
  localparam int LfoscHz = 31000;
  // Power-up timer counts low-frequency ticks: 64 ms at 31 kHz
  localparam int PwrtTicks = (PwrtMs * LfoscHz) / 1000;
  localparam int LfDivCycles = ClockHz / LfoscHz;
  // Filter on external reset: least low time in ns
  localparam int ExtFilterNs = 2000;
  localparam int ExtFilterCycles = (ExtFilterNs * (ClockHz / 1000000) + 999) / 1000;
  localparam int StretchCycles = 8;

  // Reset values
  localparam logic PowerOnFlagReset = 1'b0;
  localparam logic WakeFlagReset = 1'b1;

  typedef enum logic [2:0] {
    CausePowerOn, CauseWakeReset, CauseWdtRun, CauseWdtSleep,
    CauseExtRun, CauseExtSleep, CauseBrownout, CauseNone
  } cause_t;

  typedef struct packed {
    logic wakeResetEnable_n;
    logic dataProtect_n;
    logic programProtect_n;
    logic extResetPinEnable;
    logic powerupTimerDisable;
    logic watchdogEnableCfg;
    logic [2:0] oscSelect;
  } cfg_t;

  typedef struct packed {
    logic powerOkay;
    logic brownoutEnable;
    logic aboveBrownoutThreshold;
  } supply_t;
endpackage

// ### src/reset_pulse_filter.sv
`timescale 1ns/1ps
module reset_pulse_filter #(
  parameter int FilterCycles = 50
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstSync_n,
  // Synchronised level in, filtered level out
  input wire logic levelIn,
  output logic levelOut
);
  localparam int CntW = $clog2(FilterCycles + 1);
  logic [CntW-1:0] cnt_q;
  logic [CntW-1:0] cnt_d;
  logic levelOut_d;
  wire logic differs = levelIn != levelOut;
  wire logic expired = cnt_q >= CntW'(FilterCycles - 1);

  // A level must persist the full window before it is accepted
  assign cnt_d = (!differs || expired) ? '0 : cnt_q + CntW'(1);
  assign levelOut_d = (differs && expired) ? levelIn : levelOut;

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cnt_q <= '0;
      levelOut <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      levelOut <= levelOut_d;
    end
  end
endmodule // reset_pulse_filter

// ### src/reset_and_config_sequencer.sv
`timescale 1ns/1ps
// Function
// - Config bit 6 low enables program memory protection.
// - Bit 5 low: pin is digital input, reset tied off, pull-up on.
// - Config bit 4 high disables the power-up timer, low enables it.
// - Bit 3 high forces watchdog on; low defers to software enable.
// - Oscillator code selects clock source and pin roles.
// - Brown-out enable never turns on the power-up timer by itself.
// - Data protection turned off erases the whole data EEPROM.
// - Program protection turned off erases the whole program memory.
// - External reset in internal or RC mode stops internal oscillator.
// - Seven reset causes are distinguished and reported.
// - Retained registers unknown at power-on, kept on other resets.
// - Most registers reset on all resets except watchdog wake-up.
// - External reset input filters out short pulses.
// - Hold reset until supply adequate, or above brown-out threshold.
// - Wake reset enabled: enabled wake source resets on leaving sleep.
// - Wake reset enabled: port A bit 3 change in sleep requests wake when bit 5 is low.
// - Port A bit 3 change in sleep wakes; with bit 12 low it also resets, clears wake flag.
// - Power-up timer 64 ms after power-on or brown-out, 31 kHz base.
// - Watchdog reset is internal only, never drives the pin low.
// - Config bit 12 low selects wake followed by reset.
// - Power-on flag zero after power-on, kept until software writes one.
module reset_and_config_sequencer #(
  parameter int PwrtTickCount = rst_seq_pkg::PwrtTicks,
  parameter int LfDivide = rst_seq_pkg::LfDivCycles,
  parameter int FilterCycles = rst_seq_pkg::ExtFilterCycles
) (
  // Clock and power-on reset
  input wire logic clock,
  input wire logic rst_n,
  // Configuration word and supply monitors
  input wire logic [15:0] configuration_word,
  input wire logic powerOkay,
  input wire logic brownoutEnable,
  input wire logic aboveBrownoutThreshold,
  // External reset pin, shared with port A bit 3
  input wire logic master_clear_n,
  output logic pinPullupEnable,
  output logic pinDigitalInput,
  // Core status and requests
  input wire logic sleeping,
  input wire logic watchdogTimeout,
  input wire logic watchdog_soft_enable,
  input wire logic peripheralWake,
  input wire logic powerOnFlagWrite,
  input wire logic wakeFlagWrite,
  // Decoded configuration
  output logic programProtectActive,
  output logic dataProtectActive,
  output logic watchdogRun,
  output logic [2:0] osc_select,
  output logic clkoutEnable,
  output logic osc1IsIo,
  output logic osc2IsIo,
  output logic extRcSelected,
  output logic internalOscStop,
  // Erase requests
  output logic eraseDataMem,
  output logic eraseProgMem,
  // Resets and causes
  output logic coreReset,
  output logic retainedReset,
  output logic wakeResume,
  output logic port_a_bit3_pin,
  output logic powerOnFlag_n,
  output logic wake_reset_flag_n,
  output rst_seq_pkg::cause_t resetCause
);
  localparam int TickW = $clog2(PwrtTickCount + 1);
  localparam int DivW = $clog2(LfDivide + 1);

  rst_seq_pkg::cfg_t cfg;
  logic rstMeta_q, rstSync_n;
  logic pinS1_q, pinS2_q, pinS3_q, pinLevel_q;
  logic filtPin;
  logic [DivW-1:0] div_q;
  logic [TickW-1:0] powerup_timer_q;
  logic pwrtRun_q, pwrtStart_q;
  logic [3:0] stretch_q;
  logic coreReset_q, dataProt_q, progProt_q, sawPinHigh_q;
  logic powerOnFlag_q, wakeFlag_q, wakeResume_q;
  logic pinPrev_q;
  rst_seq_pkg::cause_t cause_q, cause_d;

  function automatic logic isInternalOrRc(input logic [2:0] code);
    return code == rst_seq_pkg::OscExtRcClkout || code == rst_seq_pkg::OscExtRcIo ||
      code == rst_seq_pkg::OscIntClkout || code == rst_seq_pkg::OscIntIo;
  endfunction

  assign cfg.wakeResetEnable_n = configuration_word[rst_seq_pkg::CfgWakeResetBit];
  assign cfg.dataProtect_n = configuration_word[rst_seq_pkg::CfgDataProtBit];
  assign cfg.programProtect_n = configuration_word[rst_seq_pkg::CfgProgProtBit];
  assign cfg.extResetPinEnable = configuration_word[rst_seq_pkg::CfgExtPinBit];
  assign cfg.powerupTimerDisable = configuration_word[rst_seq_pkg::CfgPwrtDisBit];
  assign cfg.watchdogEnableCfg = configuration_word[rst_seq_pkg::CfgWdtBit];
  assign cfg.oscSelect = configuration_word[rst_seq_pkg::CfgOscLsb +: rst_seq_pkg::CfgOscWidth];

  // Reset release through two flops
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  // Pin synchroniser; level changes once stages two and three agree
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinS1_q <= 1'b1;
      pinS2_q <= 1'b1;
      pinS3_q <= 1'b1;
      pinLevel_q <= 1'b1;
    end else begin
      pinS1_q <= master_clear_n;
      pinS2_q <= pinS1_q;
      pinS3_q <= pinS2_q;
      if (pinS2_q == pinS3_q) begin
        pinLevel_q <= pinS3_q;
      end
    end
  end

  reset_pulse_filter #(
    .FilterCycles(FilterCycles)
  ) u_filter (
    .clock(clock),
    .rstSync_n(rstSync_n),
    .levelIn(pinLevel_q),
    .levelOut(filtPin)
  );

  // Decoded configuration outputs
  assign programProtectActive = !cfg.programProtect_n;
  assign dataProtectActive = !cfg.dataProtect_n;
  assign pinDigitalInput = !cfg.extResetPinEnable;
  assign pinPullupEnable = !cfg.extResetPinEnable;
  assign watchdogRun = cfg.watchdogEnableCfg || watchdog_soft_enable;
  assign osc_select = cfg.oscSelect;
  assign clkoutEnable = cfg.oscSelect == rst_seq_pkg::OscExtRcClkout ||
    cfg.oscSelect == rst_seq_pkg::OscIntClkout;
  assign extRcSelected = cfg.oscSelect == rst_seq_pkg::OscExtRcClkout ||
    cfg.oscSelect == rst_seq_pkg::OscExtRcIo;
  assign osc1IsIo = cfg.oscSelect == rst_seq_pkg::OscIntClkout ||
    cfg.oscSelect == rst_seq_pkg::OscIntIo;
  assign osc2IsIo = cfg.oscSelect == rst_seq_pkg::OscIntIo ||
    cfg.oscSelect == rst_seq_pkg::OscExtRcIo;

  // Pin reset only counts when the pin has its reset role
  wire logic pinReset = cfg.extResetPinEnable && !filtPin;
  assign internalOscStop = pinReset && isInternalOrRc(cfg.oscSelect);
  // Bit 3 pin reads back as a plain input when not a reset pin
  assign port_a_bit3_pin = pinLevel_q;

  // Supply hold: brown-out threshold governs when enabled
  wire logic supplyBad = !powerOkay || (brownoutEnable && !aboveBrownoutThreshold);
  wire logic brownoutEvent = powerOkay && brownoutEnable && !aboveBrownoutThreshold;
  // Only the configuration bit starts the timer, never brown-out enable
  wire logic pwrtEnabled = !cfg.powerupTimerDisable;

  // Wake reset: peripheral wake or pin change while asleep
  wire logic pinChange = sleeping && !cfg.extResetPinEnable && (pinLevel_q != pinPrev_q);
  wire logic wakeSource = sleeping && (peripheralWake || pinChange);
  wire logic wakeReset = wakeSource && !cfg.wakeResetEnable_n;
  wire logic wdtReset = watchdogTimeout && !sleeping;
  wire logic wdtWake = watchdogTimeout && sleeping;
  wire logic anyRequest = supplyBad || pinReset || wakeReset || wdtReset;

  // Low-frequency tick from the system clock
  wire logic lfTick = div_q == DivW'(LfDivide - 1);
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      div_q <= '0;
    end else begin
      div_q <= lfTick ? '0 : div_q + DivW'(1);
    end
  end

  // Power-up timer: armed by power-on or brown-out, restarted on brown-out
  wire logic pwrtDone = powerup_timer_q == TickW'(PwrtTickCount);
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pwrtStart_q <= 1'b1;
      pwrtRun_q <= 1'b0;
      powerup_timer_q <= '0;
    end else if (supplyBad) begin
      pwrtStart_q <= 1'b1;
      pwrtRun_q <= 1'b0;
      powerup_timer_q <= '0;
    end else if (pwrtStart_q) begin
      pwrtStart_q <= 1'b0;
      pwrtRun_q <= pwrtEnabled;
    end else if (pwrtRun_q && lfTick) begin
      powerup_timer_q <= powerup_timer_q + TickW'(1);
      pwrtRun_q <= !(powerup_timer_q == TickW'(PwrtTickCount - 1));
    end
  end

  wire logic holdReset = anyRequest || pwrtStart_q || pwrtRun_q;

  // Short stretch so one-cycle requests still produce a clean reset
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stretch_q <= 4'hF;
      coreReset_q <= 1'b1;
    end else begin
      if (holdReset) begin
        stretch_q <= 4'(rst_seq_pkg::StretchCycles);
      end else if (stretch_q != 4'h0) begin
        stretch_q <= stretch_q - 4'h1;
      end
      coreReset_q <= holdReset || (stretch_q != 4'h0);
    end
  end
  assign coreReset = coreReset_q;
  // Retained registers see only the power-on reset
  assign retainedReset = !rstSync_n;
  assign wakeResume = wakeResume_q;

  // Cause capture, highest priority first
  always_comb begin
    cause_d = cause_q;
    if (!powerOkay) begin
      cause_d = rst_seq_pkg::CausePowerOn;
    end else if (brownoutEvent) begin
      cause_d = rst_seq_pkg::CauseBrownout;
    end else if (pinReset) begin
      cause_d = sleeping ? rst_seq_pkg::CauseExtSleep : rst_seq_pkg::CauseExtRun;
    end else if (wakeReset) begin
      cause_d = rst_seq_pkg::CauseWakeReset;
    end else if (wdtReset) begin
      cause_d = rst_seq_pkg::CauseWdtRun;
    end else if (wdtWake) begin
      cause_d = rst_seq_pkg::CauseWdtSleep;
    end
  end

  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cause_q <= rst_seq_pkg::CausePowerOn;
      pinPrev_q <= 1'b1;
      wakeResume_q <= 1'b0;
    end else begin
      cause_q <= cause_d;
      pinPrev_q <= pinLevel_q;
      // Watchdog wake resumes without resetting registers
      wakeResume_q <= wdtWake || (wakeSource && cfg.wakeResetEnable_n);
    end
  end
  assign resetCause = cause_q;

  // Power-on and wake flags; hardware clear wins over software write
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      powerOnFlag_q <= rst_seq_pkg::PowerOnFlagReset;
      wakeFlag_q <= rst_seq_pkg::WakeFlagReset;
    end else begin
      if (!powerOkay) begin
        powerOnFlag_q <= 1'b0;
      end else if (powerOnFlagWrite) begin
        powerOnFlag_q <= 1'b1;
      end
      if (wakeReset) begin
        wakeFlag_q <= 1'b0;
      end else if (wakeFlagWrite) begin
        wakeFlag_q <= 1'b1;
      end
    end
  end
  assign powerOnFlag_n = powerOnFlag_q;
  assign wake_reset_flag_n = wakeFlag_q;

  // Erase when protection goes from enabled to disabled; seen only after first sample
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      dataProt_q <= 1'b0;
      progProt_q <= 1'b0;
      sawPinHigh_q <= 1'b0;
      eraseDataMem <= 1'b0;
      eraseProgMem <= 1'b0;
    end else begin
      sawPinHigh_q <= 1'b1;
      dataProt_q <= dataProtectActive;
      progProt_q <= programProtectActive;
      eraseDataMem <= sawPinHigh_q && dataProt_q && !dataProtectActive;
      eraseProgMem <= sawPinHigh_q && progProt_q && !programProtectActive;
    end
  end
endmodule // reset_and_config_sequencer

// ### verification/reset_and_config_sequencer_properties.sv
`timescale 1ns/1ps
module reset_and_config_sequencer_properties #(
  parameter int PwrtTickCount = 4,
  parameter int LfDivide = 2,
  parameter int FilterCycles = 3
) (
  // Clock, reset and inputs
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [15:0] configuration_word,
  input wire logic powerOkay,
  input wire logic brownoutEnable,
  input wire logic aboveBrownoutThreshold,
  input wire logic master_clear_n,
  input wire logic watchdog_soft_enable,
  // Outputs
  input wire logic programProtectActive,
  input wire logic pinPullupEnable,
  input wire logic watchdogRun,
  input wire logic [2:0] osc_select,
  input wire logic clkoutEnable,
  input wire logic extRcSelected,
  input wire logic eraseProgMem,
  input wire logic coreReset,
  input wire logic powerOnFlag_n
);
  localparam int HoldMax = PwrtTickCount * LfDivide + 12;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_prot; programProtectActive == !configuration_word[6]; endproperty
  a_prot: assert property (p_prot) else $error("protect decode");
  property p_pin; pinPullupEnable == !configuration_word[5]; endproperty
  a_pin: assert property (p_pin) else $error("pin mode decode");
  property p_wdt; watchdogRun == (configuration_word[3] || watchdog_soft_enable); endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog enable");
  property p_osc; configuration_word[2] |-> osc_select == configuration_word[2:0]
    && clkoutEnable == configuration_word[0] && extRcSelected == configuration_word[1]; endproperty
  a_osc: assert property (p_osc) else $error("oscillator decode");
  property p_erase; $rose(configuration_word[6]) |-> ##[0:2] eraseProgMem; endproperty
  a_erase: assert property (p_erase) else $error("no program erase");
  property p_ext; (configuration_word[5] && !master_clear_n) [*8] |-> ##[0:3] coreReset; endproperty
  a_ext: assert property (p_ext) else $error("pin reset missed");
  property p_hold; !powerOkay |-> ##[1:2] (coreReset && !powerOnFlag_n); endproperty
  a_hold: assert property (p_hold) else $error("supply loss not held");
  property p_powerup_timer; $rose(aboveBrownoutThreshold) && brownoutEnable && !configuration_word[4]
    |-> coreReset [*8] ##1 coreReset [*7] ##[1:HoldMax] !coreReset; endproperty
  a_powerup_timer: assert property (p_powerup_timer) else $error("power-up timer span");
  c_reset: cover property ($rose(coreReset));
  c_erase: cover property (eraseProgMem);
  c_soft: cover property (watchdogRun && !configuration_word[3]);
endmodule // reset_and_config_sequencer_properties

bind reset_and_config_sequencer reset_and_config_sequencer_properties #(
  .PwrtTickCount(PwrtTickCount), .LfDivide(LfDivide), .FilterCycles(FilterCycles)
) reset_and_config_sequencer_properties_inst (.*);

// ### verification/supply_pin_model.sv
`timescale 1ns/1ps
module supply_pin_model (
  // Clock
  input wire logic clock,
  // Monitor levels and pin
  output logic powerOkay,
  output logic aboveBrownoutThreshold,
  output logic master_clear_n
);
  initial begin
    powerOkay = 1'b1;
    aboveBrownoutThreshold = 1'b1;
    master_clear_n = 1'b1;
  end
  // A full loss also takes the level below the brown-out threshold
  task automatic dip(input int n, input logic full);
    @(posedge clock);
    powerOkay <= !full;
    aboveBrownoutThreshold <= 1'b0;
    repeat (n) @(posedge clock);
    powerOkay <= 1'b1;
    aboveBrownoutThreshold <= 1'b1;
  endtask
  // Released pin returns high through its resistor
  task automatic press(input int n);
    @(posedge clock);
    master_clear_n <= 1'b0;
    repeat (n) @(posedge clock);
    master_clear_n <= 1'b1;
  endtask
endmodule // supply_pin_model

// ### verification/reset_and_config_sequencer_bench.sv
`timescale 1ns/1ps
module reset_and_config_sequencer_bench;
  logic clock, rst_n, brownoutEnable, sleeping, watchdogTimeout, watchdog_soft_enable;
  logic peripheralWake, powerOnFlagWrite, wakeFlagWrite, powerOkay, aboveBrownoutThreshold;
  logic master_clear_n, pinPullupEnable, pinDigitalInput, programProtectActive;
  logic dataProtectActive, watchdogRun, clkoutEnable, osc1IsIo, osc2IsIo, extRcSelected;
  logic internalOscStop, eraseDataMem, eraseProgMem, coreReset, retainedReset, wakeResume;
  logic port_a_bit3_pin, powerOnFlag_n, wake_reset_flag_n;
  logic [2:0] osc_select;
  logic [15:0] configuration_word;
  logic [1:0] seen;
  rst_seq_pkg::cause_t resetCause;
  int num_errors = 0;
  int num_checks = 0;
  int n;
  reset_and_config_sequencer #(.PwrtTickCount(4), .LfDivide(2), .FilterCycles(3))
    reset_and_config_sequencer_inst (.*);
  supply_pin_model supply_pin_model_inst (.*);

  initial begin
    clock = 1'b0;
    forever #20 clock = !clock;
  end

  task automatic print_verdict;
    if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitOut(output int c);
    c = 0;
    @(negedge clock);
    while (coreReset !== 1'b0) begin
      @(negedge clock);
      c++;
      if (c > 400) begin
        num_errors++;
        print_verdict();
      end
    end
  endtask
  task automatic watch(input int c);
    seen = 2'b00;
    repeat (c) begin
      @(negedge clock);
      seen |= {coreReset, wakeResume};
    end
  endtask
  task automatic cfg(input logic [15:0] w);
    @(posedge clock);
    configuration_word <= w;
  endtask
  // One-cycle strobe: 0 watchdog, 1 power-on flag write, 2 wake flag write, 3 wake source
  task automatic pulse(input int which);
    @(posedge clock);
    case (which)
      0: watchdogTimeout <= 1'b1;
      1: powerOnFlagWrite <= 1'b1;
      2: wakeFlagWrite <= 1'b1;
      default: peripheralWake <= 1'b1;
    endcase
    @(posedge clock);
    case (which)
      0: watchdogTimeout <= 1'b0;
      1: powerOnFlagWrite <= 1'b0;
      2: wakeFlagWrite <= 1'b0;
      default: peripheralWake <= 1'b0;
    endcase
  endtask

  task automatic decodeAll;
    logic [15:0] w;
    for (int c = 4; c < 8; c++) begin
      w = {7'h08, 1'b0, 1'b1, c[0], c[1], 1'b0, c[0] ^ c[1], c[2:0]};
      cfg(w);
      watchdog_soft_enable <= c[0];
      @(negedge clock);
      check("decode", {!w[6], !w[5], !w[5], w[3] | w[0], w[2:0], 1'b0}, {programProtectActive,
        pinPullupEnable, pinDigitalInput, watchdogRun, osc_select, 1'b0});
      check("pin roles", {4'h0, w[0], w[1], !w[1], !w[0]},
        {4'h0, clkoutEnable, extRcSelected, osc1IsIo, osc2IsIo});
    end
  endtask
  task automatic eraseBoth;
    logic [1:0] e;
    e = 2'b00;
    cfg(16'h1025);
    cfg(16'h10E5);
    repeat (4) begin
      @(negedge clock);
      e |= {eraseDataMem, eraseProgMem};
    end
    check("erase", 8'h03, e);
  endtask
  task automatic pinReset;
    supply_pin_model_inst.press(2);
    watch(12);
    check("short pulse", 8'h00, seen);
    fork
      supply_pin_model_inst.press(12);
      begin
        repeat (10) @(negedge clock);
        check("osc stop", 8'h03, {internalOscStop, coreReset});
      end
    join
    waitOut(n);
    check("pin cause", rst_seq_pkg::CauseExtRun, resetCause);
    cfg(16'h10C5);
    supply_pin_model_inst.press(12);
    watch(12);
    check("pin as input", 8'h00, seen);
    cfg(16'h10E5);
  endtask
  task automatic supplyLoss;
    fork
      supply_pin_model_inst.dip(4, 1'b1);
      begin
        repeat (3) @(negedge clock);
        check("supply loss", 8'h03, {coreReset, !powerOnFlag_n});
      end
    join
    waitOut(n);
    check("loss cause", rst_seq_pkg::CausePowerOn, resetCause);
    check("loss span", 8'h01, n >= 15);
  endtask
  task automatic brownout;
    cfg(16'h10F5);
    brownoutEnable <= 1'b1;
    supply_pin_model_inst.dip(4, 1'b0);
    waitOut(n);
    check("brown-out cause", rst_seq_pkg::CauseBrownout, resetCause);
    check("no timer", 8'h01, n < 15);
    cfg(16'h10E5);
    supply_pin_model_inst.dip(4, 1'b0);
    waitOut(n);
    check("brown-out span", 8'h01, n >= 15);
    @(posedge clock);
    brownoutEnable <= 1'b0;
  endtask
  task automatic watchdog;
    pulse(0);
    watch(4);
    check("watchdog reset", 8'h02, seen);
    waitOut(n);
    check("watchdog cause", rst_seq_pkg::CauseWdtRun, resetCause);
    check("retained", 8'h00, retainedReset);
    @(posedge clock);
    sleeping <= 1'b1;
    pulse(0);
    watch(12);
    check("watchdog wake", 8'h01, seen);
    check("wake cause", rst_seq_pkg::CauseWdtSleep, resetCause);
  endtask
  task automatic wakeReset;
    cfg(16'h00C5);
    supply_pin_model_inst.press(6);
    watch(12);
    check("pin wake", 8'h02, {seen[1], 1'b0});
    check("wake flag", 8'h00, wake_reset_flag_n);
    check("wake cause", rst_seq_pkg::CauseWakeReset, resetCause);
    @(posedge clock);
    sleeping <= 1'b0;
    waitOut(n);
    pulse(2);
    @(negedge clock);
    check("wake flag set", 8'h01, wake_reset_flag_n);
    for (int i = 0; i < 2; i++) begin
      cfg({3'h0, i[0], 12'h0C5});
      sleeping <= 1'b1;
      pulse(3);
      watch(6);
      check("wake source", i ? 8'h01 : 8'h02, seen);
      @(posedge clock);
      sleeping <= 1'b0;
      waitOut(n);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    brownoutEnable = 1'b0;
    sleeping = 1'b0;
    watchdogTimeout = 1'b0;
    watchdog_soft_enable = 1'b0;
    peripheralWake = 1'b0;
    powerOnFlagWrite = 1'b0;
    wakeFlagWrite = 1'b0;
    configuration_word = 16'h10E5;
    repeat (6) @(negedge clock);
    check("power-on hold", 8'h07, {retainedReset, !powerOnFlag_n, coreReset});
    check("power-on cause", rst_seq_pkg::CausePowerOn, resetCause);
    @(posedge clock);
    rst_n <= 1'b1;
    waitOut(n);
    check("power-up span", 8'h01, n >= 15);
    decodeAll();
    eraseBoth();
    pulse(1);
    pinReset();
    check("flag kept", 8'h01, powerOnFlag_n);
    supplyLoss();
    brownout();
    watchdog();
    wakeReset();
    print_verdict();
  end
endmodule // reset_and_config_sequencer_bench
